// ===== hw/dsp_pkg.sv
package dsp_pkg;
  localparam int CLK_MHZ     = 250;
  localparam int CYC_PER_MS  = CLK_MHZ * 1000;
  localparam int MOTOR_MS    = 500;
  localparam int MOTOR525_MS = 750;
  localparam int DIRCHG_MS   = 15;
  localparam int SETTLE_MS   = 15;
  localparam int STEP_NS     = 1000;
  localparam int WPULSE_NS   = 125;
  localparam int MOTOR_CYC    = MOTOR_MS * CYC_PER_MS;
  localparam int MOTOR525_CYC = MOTOR525_MS * CYC_PER_MS;
  localparam int DIRCHG_CYC   = DIRCHG_MS * CYC_PER_MS;
  localparam int SETTLE_CYC   = SETTLE_MS * CYC_PER_MS;
  localparam int STEP_CYC     = (STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPULSE_CYC   = (WPULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 28;
  localparam int WP_W  = 6;
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] ADR_ST1  = 8'h00;
  localparam logic [ADR_W-1:0] ADR_ST2  = 8'h04;
  localparam logic [ADR_W-1:0] ADR_ST3  = 8'h08;
  localparam logic [ADR_W-1:0] ADR_CTRL = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_STEP = 8'h10;
  localparam logic [ADR_W-1:0] ADR_STAT = 8'h14;
  localparam int ST1_EOT = 7, ST1_RSV6 = 6, ST1_CRC = 5, ST1_OVR = 4;
  localparam int ST1_RSV3 = 3, ST1_NODATA = 2, ST1_NOWR = 1, ST1_NOAM = 0;
  localparam int ST2_RSV7 = 7, ST2_CTLMARK = 6, ST2_DCRC = 5, ST2_WTRK = 4;
  localparam int ST2_SEQ = 3, ST2_SNS = 2, ST2_BADTRK = 1, ST2_DAM = 0;
  localparam int ST3_WP = 6, ST3_T0 = 4, ST3_HD = 2, ST3_US = 0;
  localparam logic [7:0] ST3_FIXED = 8'h28;
  localparam int CTRL_SEL = 0, CTRL_UNIT = 1, CTRL_MOTOR = 3, CTRL_HEAD = 4;
  localparam int CTRL_HD = 5, CTRL_K525 = 6, CTRL_WGATE = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int STEP_DIR = 0;
  localparam int STAT_BUSY = 0, STAT_MOTOK = 1, STAT_READY = 2, STAT_CHG = 3;
  localparam int STAT_IDX = 4, STAT_UKIND = 5, STAT_MKIND = 7;
  localparam logic [7:0] TRK_NONE = 8'hFF;
  localparam int PIN_IDX = 0, PIN_T0 = 1, PIN_WP = 2, PIN_RD = 3, PIN_CHG = 4;
  localparam int PIN_UK = 5, PIN_MK = 7;
  localparam int SYNC_W = 9;
  localparam logic [SYNC_W-1:0] SYNC_RST = 9'h1FF;
  typedef enum logic [2:0] {
    STP_IDLE, STP_SETUP, STP_PULSE, STP_HOLD, STP_SETTLE
  } dsp_step_type;
endpackage : dsp_pkg

// ===== hw/dsp_sync3.sv
module dsp_sync3 (
  input  wire logic                      core_clk, // system clock
  input  wire logic                      rst,      // sync reset, high
  input  wire logic [dsp_pkg::SYNC_W-1:0] d,       // raw pin levels
  output logic      [dsp_pkg::SYNC_W-1:0] q        // filtered levels
);
  logic [dsp_pkg::SYNC_W-1:0] s1_ff;
  logic [dsp_pkg::SYNC_W-1:0] s2_ff;
  logic [dsp_pkg::SYNC_W-1:0] s3_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_ff <= dsp_pkg::SYNC_RST;
      s2_ff <= dsp_pkg::SYNC_RST;
      s3_ff <= dsp_pkg::SYNC_RST;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a bit only moves once stages two and three agree
  genvar i;
  for (i = 0; i < dsp_pkg::SYNC_W; i++) begin : g_agree
    always_ff @(posedge core_clk) begin
      if (rst) begin
        q[i] <= dsp_pkg::SYNC_RST[i];
      end else if (s2_ff[i] == s3_ff[i]) begin
        q[i] <= s3_ff[i];
      end
    end
  end
endmodule : dsp_sync3

// ===== hw/dsp_top.sv
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
module dsp_top #(
  parameter int MOTOR_CYC    = dsp_pkg::MOTOR_CYC,
  parameter int MOTOR525_CYC = dsp_pkg::MOTOR525_CYC,
  parameter int DIRCHG_CYC   = dsp_pkg::DIRCHG_CYC,
  parameter int SETTLE_CYC   = dsp_pkg::SETTLE_CYC
) (
  input  wire logic                     core_clk,       // 250 MHz clock
  input  wire logic                     rst,            // sync reset, high
  input  wire logic                     wb_cyc_i,       // bus cycle
  input  wire logic                     wb_stb_i,       // bus strobe
  input  wire logic                     wb_we_i,        // write
  input  wire logic [dsp_pkg::ADR_W-1:0] wb_adr_i,      // byte address
  input  wire logic [3:0]               wb_sel_i,       // byte lanes
  input  wire logic [31:0]              wb_dat_i,       // write data
  output logic      [31:0]              wb_dat_o,       // read data
  output logic                          wb_ack_o,       // ack
  input  wire logic                     cmd_start,      // new command pulse
  input  wire logic                     cmd_write_type, // write/format active
  input  wire logic                     ev_past_eot,    // past last sector
  input  wire logic                     ev_crc_id,      // id checksum bad
  input  wire logic                     ev_crc_data,    // data checksum bad
  input  wire logic                     ev_overrun,     // host too slow
  input  wire logic                     ev_no_data,     // sector/id not found
  input  wire logic                     ev_id_mark_miss, // no id mark
  input  wire logic                     ev_dat_mark_miss, // no data mark
  input  wire logic                     ev_mark_mismatch, // mark type differs
  input  wire logic                     trk_check,      // compare tracks now
  input  wire logic [7:0]               medium_track,   // track from medium
  input  wire logic [7:0]               expected_track, // commanded track
  input  wire logic                     ev_scan_equal,  // scan equal met
  input  wire logic                     ev_scan_miss,   // scan not met
  input  wire logic                     flux_req,       // write one reversal
  output logic                          op_ready,       // access allowed
  output logic                          idx_pulse,      // index seen
  output logic                          rd_pulse,       // read reversal seen
  output logic                          sel_n,          // drive select
  output logic                          motor_n,        // motor enable
  output logic                          dir_n,          // direction in
  output logic                          step_n,         // step
  output logic                          wdata_n,        // write data
  output logic                          wen_n,          // write enable
  output logic                          head_n,         // head 1 select
  output logic                          density_n,      // high density
  input  wire logic                     index_n,        // index pin
  input  wire logic                     track0_n,       // track zero pin
  input  wire logic                     wprot_n,        // write protect pin
  input  wire logic                     rdata_n,        // read data pin
  input  wire logic                     chg_n,          // disk change pin
  input  wire logic [1:0]               unit_kind_code, // drive type
  input  wire logic [1:0]               medium_kind_code // medium type
);
  logic [7:0]                st1_ff, nxt_st1;
  logic [7:0]                st2_ff, nxt_st2;
  logic [7:0]                st3;
  logic [7:0]                ctrl_ff;
  logic                      ack_ff;
  logic [31:0]               dat_ff;
  logic [31:0]               rd_mux;
  logic [dsp_pkg::SYNC_W-1:0] pin_q;
  logic [dsp_pkg::SYNC_W-1:0] pin_prev_ff;
  logic [dsp_pkg::CNT_W-1:0] mot_cnt_ff;
  logic                      mot_ok;
  dsp_pkg::dsp_step_type     state_ff, nxt_state;
  logic [dsp_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic                      dir_ff, nxt_dir;
  logic                      dirchg_ff, nxt_dirchg;
  logic                      req_ff, req_dir_ff;
  logic                      take;
  logic [dsp_pkg::WP_W-1:0]  wp_cnt_ff;
  logic                      wen_ff;
  logic                      wr_acc, wr_step;
  logic                      wp_act;

  function automatic logic reached(input logic [dsp_pkg::CNT_W-1:0] c, input int n);
    reached = (c >= dsp_pkg::CNT_W'(n - 1));
  endfunction : reached

  dsp_sync3 u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({medium_kind_code, unit_kind_code, chg_n, rdata_n, wprot_n,
                track0_n, index_n}),
    .q        (pin_q)
  );

  assign wp_act = ~pin_q[dsp_pkg::PIN_WP];

  // bus slave: ack one cycle after the request, then drop
  assign wr_acc  = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_ff & wb_sel_i[0];
  assign wr_step = wr_acc & (wb_adr_i == dsp_pkg::ADR_STEP);

  always_comb begin
    rd_mux = '0;
    case (wb_adr_i)
      dsp_pkg::ADR_ST1:  rd_mux[7:0] = st1_ff;
      dsp_pkg::ADR_ST2:  rd_mux[7:0] = st2_ff;
      dsp_pkg::ADR_ST3:  rd_mux[7:0] = st3;
      dsp_pkg::ADR_CTRL: rd_mux[7:0] = ctrl_ff;
      dsp_pkg::ADR_STAT: begin
        rd_mux[dsp_pkg::STAT_BUSY]  = (state_ff != dsp_pkg::STP_IDLE) | req_ff;
        rd_mux[dsp_pkg::STAT_MOTOK] = mot_ok;
        rd_mux[dsp_pkg::STAT_READY] = op_ready;
        rd_mux[dsp_pkg::STAT_CHG]   = ~pin_q[dsp_pkg::PIN_CHG];
        rd_mux[dsp_pkg::STAT_IDX]   = ~pin_q[dsp_pkg::PIN_IDX];
        rd_mux[dsp_pkg::STAT_UKIND +: 2] = pin_q[dsp_pkg::PIN_UK +: 2];
        rd_mux[dsp_pkg::STAT_MKIND +: 2] = pin_q[dsp_pkg::PIN_MK +: 2];
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end else begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
      if (wb_cyc_i & wb_stb_i & ~ack_ff) begin
        dat_ff <= rd_mux;
      end
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_ff <= dsp_pkg::CTRL_RST;
    end else if (wr_acc && wb_adr_i == dsp_pkg::ADR_CTRL) begin
      ctrl_ff <= wb_dat_i[7:0];
    end
  end

  // result status: a new command clears, any event in that cycle still sets
  always_comb begin
    nxt_st1 = cmd_start ? 8'h00 : st1_ff;
    nxt_st2 = cmd_start ? 8'h00 : st2_ff;
    if (ev_past_eot) nxt_st1[dsp_pkg::ST1_EOT] = 1'b1;
    if (ev_crc_id | ev_crc_data) nxt_st1[dsp_pkg::ST1_CRC] = 1'b1;
    if (ev_crc_data) nxt_st2[dsp_pkg::ST2_DCRC] = 1'b1;
    if (ev_overrun) nxt_st1[dsp_pkg::ST1_OVR] = 1'b1;
    if (ev_no_data) nxt_st1[dsp_pkg::ST1_NODATA] = 1'b1;
    if (cmd_write_type & wp_act) nxt_st1[dsp_pkg::ST1_NOWR] = 1'b1;
    if (ev_id_mark_miss) begin
      nxt_st1[dsp_pkg::ST1_NOAM] = 1'b1;
      nxt_st2[dsp_pkg::ST2_DAM]  = 1'b0;
    end
    if (ev_dat_mark_miss) begin
      nxt_st1[dsp_pkg::ST1_NOAM] = 1'b1;
      nxt_st2[dsp_pkg::ST2_DAM]  = 1'b1;
    end
    if (ev_mark_mismatch) nxt_st2[dsp_pkg::ST2_CTLMARK] = 1'b1;
    if (trk_check && medium_track != expected_track) begin
      nxt_st2[dsp_pkg::ST2_WTRK]   = 1'b1;
      nxt_st1[dsp_pkg::ST1_NODATA] = 1'b1;
    end
    if (trk_check && medium_track == dsp_pkg::TRK_NONE
        && expected_track != dsp_pkg::TRK_NONE) begin
      nxt_st2[dsp_pkg::ST2_BADTRK] = 1'b1;
      nxt_st1[dsp_pkg::ST1_NODATA] = 1'b1;
    end
    if (ev_scan_equal) nxt_st2[dsp_pkg::ST2_SEQ] = 1'b1;
    if (ev_scan_miss) nxt_st2[dsp_pkg::ST2_SNS] = 1'b1;
    nxt_st1[dsp_pkg::ST1_RSV6] = 1'b0;
    nxt_st1[dsp_pkg::ST1_RSV3] = 1'b0;
    nxt_st2[dsp_pkg::ST2_RSV7] = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st1_ff <= 8'h00;
      st2_ff <= 8'h00;
    end else begin
      st1_ff <= nxt_st1;
      st2_ff <= nxt_st2;
    end
  end

  // live snapshot, fixed bits 5 and 3 high, bit 7 low
  always_comb begin
    st3 = dsp_pkg::ST3_FIXED;
    st3[dsp_pkg::ST3_WP] = wp_act;
    st3[dsp_pkg::ST3_T0] = ~pin_q[dsp_pkg::PIN_T0];
    st3[dsp_pkg::ST3_HD] = ctrl_ff[dsp_pkg::CTRL_HEAD];
    st3[dsp_pkg::ST3_US +: 2] = ctrl_ff[dsp_pkg::CTRL_UNIT +: 2];
  end

  // pulses from an unselected drive are not trusted
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_prev_ff <= dsp_pkg::SYNC_RST;
    end else begin
      pin_prev_ff <= pin_q;
    end
  end
  assign idx_pulse = ctrl_ff[dsp_pkg::CTRL_SEL] & pin_prev_ff[dsp_pkg::PIN_IDX]
                     & ~pin_q[dsp_pkg::PIN_IDX];
  assign rd_pulse  = ctrl_ff[dsp_pkg::CTRL_SEL] & pin_prev_ff[dsp_pkg::PIN_RD]
                     & ~pin_q[dsp_pkg::PIN_RD];

  // spin-up timer restarts whenever the motor is switched off
  always_ff @(posedge core_clk) begin
    if (rst || !ctrl_ff[dsp_pkg::CTRL_MOTOR]) begin
      mot_cnt_ff <= '0;
    end else if (!mot_ok) begin
      mot_cnt_ff <= mot_cnt_ff + 1'b1;
    end
  end
  assign mot_ok = ctrl_ff[dsp_pkg::CTRL_MOTOR] & (mot_cnt_ff >= (ctrl_ff[dsp_pkg::CTRL_K525]
                  ? dsp_pkg::CNT_W'(MOTOR525_CYC) : dsp_pkg::CNT_W'(MOTOR_CYC)));

  // one step per write; writes while busy are dropped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_ff     <= 1'b0;
      req_dir_ff <= 1'b0;
    end else if (take) begin
      req_ff <= 1'b0;
    end else if (wr_step && !req_ff && state_ff == dsp_pkg::STP_IDLE) begin
      req_ff     <= 1'b1;
      req_dir_ff <= wb_dat_i[dsp_pkg::STEP_DIR];
    end
  end

  // every step gets full settle, trading seek speed for simplicity
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff + 1'b1;
    nxt_dir    = dir_ff;
    nxt_dirchg = dirchg_ff;
    take       = 1'b0;
    case (state_ff)
      dsp_pkg::STP_IDLE: begin
        nxt_cnt = '0;
        if (req_ff && mot_ok) begin
          take       = 1'b1;
          nxt_dir    = req_dir_ff;
          nxt_dirchg = req_dir_ff != dir_ff;
          nxt_state  = dsp_pkg::STP_SETUP;
        end
      end
      dsp_pkg::STP_SETUP: begin
        if (reached(cnt_ff, dirchg_ff ? DIRCHG_CYC : dsp_pkg::STEP_CYC)) begin
          nxt_cnt   = '0;
          nxt_state = dsp_pkg::STP_PULSE;
        end
      end
      dsp_pkg::STP_PULSE: begin
        if (reached(cnt_ff, dsp_pkg::STEP_CYC)) begin
          nxt_cnt   = '0;
          nxt_state = dsp_pkg::STP_HOLD;
        end
      end
      dsp_pkg::STP_HOLD: begin
        if (reached(cnt_ff, dsp_pkg::STEP_CYC)) begin
          nxt_cnt   = '0;
          nxt_state = dsp_pkg::STP_SETTLE;
        end
      end
      dsp_pkg::STP_SETTLE: begin
        if (reached(cnt_ff, SETTLE_CYC)) begin
          nxt_cnt   = '0;
          nxt_state = dsp_pkg::STP_IDLE;
        end
      end
      default: begin
        nxt_cnt   = '0;
        nxt_state = dsp_pkg::STP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff  <= dsp_pkg::STP_IDLE;
      cnt_ff    <= '0;
      dir_ff    <= 1'b0;
      dirchg_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      dir_ff    <= nxt_dir;
      dirchg_ff <= nxt_dirchg;
    end
  end

  assign op_ready = mot_ok & (state_ff == dsp_pkg::STP_IDLE) & ~req_ff;

  // write gate opens only once spin-up and settle are done
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wen_ff <= 1'b0;
    end else begin
      wen_ff <= ctrl_ff[dsp_pkg::CTRL_WGATE] & ctrl_ff[dsp_pkg::CTRL_SEL]
                & op_ready & ~wp_act;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp_cnt_ff <= '0;
    end else if (wp_cnt_ff != '0) begin
      wp_cnt_ff <= wp_cnt_ff - 1'b1;
    end else if (flux_req && wen_ff) begin
      wp_cnt_ff <= dsp_pkg::WP_W'(dsp_pkg::WPULSE_CYC);
    end
  end

  assign sel_n     = ~ctrl_ff[dsp_pkg::CTRL_SEL];
  assign motor_n   = ~ctrl_ff[dsp_pkg::CTRL_MOTOR];
  assign dir_n     = ~dir_ff;
  assign step_n    = state_ff != dsp_pkg::STP_PULSE;
  assign wdata_n   = wp_cnt_ff == '0;
  assign wen_n     = ~wen_ff;
  assign head_n    = ~ctrl_ff[dsp_pkg::CTRL_HEAD];
  assign density_n = ~ctrl_ff[dsp_pkg::CTRL_HD];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [8:0] lo_cnt_ff;
  always_ff @(posedge core_clk) begin
    if (rst || step_n) lo_cnt_ff <= '0;
    else lo_cnt_ff <= lo_cnt_ff + 1'b1;
  end
  localparam logic [8:0] STEP_LO = 9'(dsp_pkg::STEP_CYC);

  property p_eot;
    ev_past_eot |=> st1_ff[dsp_pkg::ST1_EOT];
  endproperty
  a_eot: assert property (p_eot) else $error("eot flag missing");
  property p_crc;
    ev_crc_data |=> st1_ff[dsp_pkg::ST1_CRC] && st2_ff[dsp_pkg::ST2_DCRC];
  endproperty
  a_crc: assert property (p_crc) else $error("data crc flags");
  property p_nowr;
    cmd_write_type && wp_act |=> st1_ff[dsp_pkg::ST1_NOWR];
  endproperty
  a_nowr: assert property (p_nowr) else $error("protect flag");
  property p_rsv;
    !st1_ff[dsp_pkg::ST1_RSV6] && !st1_ff[dsp_pkg::ST1_RSV3] && !st2_ff[dsp_pkg::ST2_RSV7]
      && (st3 & 8'hA8) == dsp_pkg::ST3_FIXED;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_bad;
    trk_check && medium_track == 8'hFF && expected_track != 8'hFF
      |=> st2_ff[1] && st1_ff[2] && st2_ff[4];
  endproperty
  a_bad: assert property (p_bad) else $error("bad track flags");
  property p_clr;
    cmd_start && !ev_past_eot && !ev_crc_id && !ev_crc_data && !ev_overrun
      && !ev_no_data && !ev_id_mark_miss && !ev_dat_mark_miss && !trk_check
      && !cmd_write_type |=> st1_ff == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("status not cleared");
  property p_steplen;
    $rose(step_n) |-> $past(lo_cnt_ff) == STEP_LO - 9'h001;
  endproperty
  a_steplen: assert property (p_steplen) else $error("step width");
  property p_dir;
    $fell(step_n) |-> $stable(dir_n) [*8] ##1 !$changed(dir_n);
  endproperty
  a_dir: assert property (p_dir) else $error("dir moved near step");
  property p_mot;
    $fell(step_n) |-> mot_ok;
  endproperty
  a_mot: assert property (p_mot) else $error("step before spin-up");
  property p_wen;
    !wen_n |-> $past(op_ready);
  endproperty
  a_wen: assert property (p_wen) else $error("write gate early");

  c_step: cover property ($rose(step_n));
  c_wr:   cover property (!wdata_n && !wen_n);
  c_rd:   cover property (wb_ack_o && !wb_we_i);
endmodule : dsp_top

// ===== verif/dsp_drive_model.sv
module dsp_drive_model #(
  parameter int REV_CYC = 2000, // shortened spindle turn
  parameter int IDX_CYC = 300   // shortened index low time
) (
  input  wire logic       core_clk, // bench clock
  input  wire logic       sel_n,    // unit select
  input  wire logic       motor_n,  // spindle on
  input  wire logic       dir_n,    // inward when low
  input  wire logic       step_n,   // step
  input  wire logic       protect,  // medium protected
  output logic            index_n,  // index
  output logic            track0_n, // head on track 0
  output logic            wprot_n,  // protect line
  output logic            rdata_n,  // flux reversal
  output logic            chg_n,    // medium changed
  output logic [1:0]      ukind,    // unit kind
  output logic [1:0]      mkind     // medium kind
);
  timeunit 1ns;
  timeprecision 1ps;
  int   trk   = 0;
  int   rot   = 0;
  logic chg   = 1'b1;
  logic stp_q = 1'b1;
  always @(posedge core_clk) begin
    stp_q <= step_n;
    rot <= (motor_n == 1'b0) ? (rot + 1) % REV_CYC : rot;
    // direction taken at the trailing edge, only when selected
    if (sel_n == 1'b0 && stp_q == 1'b0 && step_n == 1'b1) begin
      trk <= (dir_n == 1'b0) ? trk + 1 : ((trk > 0) ? trk - 1 : 0);
      chg <= 1'b0;
    end
  end
  // deselected lines float up to the terminator level
  assign index_n  = sel_n || !(motor_n == 1'b0 && rot < IDX_CYC);
  assign rdata_n  = sel_n || !(motor_n == 1'b0 && rot % 64 < 32);
  assign track0_n = sel_n || trk != 0;
  assign wprot_n  = sel_n || !protect;
  assign chg_n    = sel_n || !chg;
  assign ukind    = sel_n ? 2'h3 : 2'h1;
  assign mkind    = sel_n ? 2'h3 : 2'h2;
endmodule : dsp_drive_model

// ===== verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MT = 300;
  localparam int ST = 300;
  localparam int DC = 260;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, m_trk = 8'h00, e_trk = 8'h00, m, e;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [9:0] ev = 10'h000;
  logic cmd_start = 1'b0, cmd_wr = 1'b0, trk_check = 1'b0, flux_req = 1'b0, protect = 1'b0;
  logic wb_ack_o, op_ready, sel_n, motor_n, dir_n, step_n, wdata_n, wen_n, density_n;
  logic head_n, idx_pulse, rd_pulse;
  int n_idx = 0;
  int n_rd = 0;
  logic index_n, track0_n, wprot_n, rdata_n, chg_n;
  logic [1:0] ukind, mkind;
  logic [7:0] exp_q[$];
  string nm_q[$];
  int fail_count = 0;
  int n_compared = 0;
  int seed = 5;
  int n;
  logic [7:0] s1 [10] = '{8'h80, 8'h20, 8'h20, 8'h10, 8'h04, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0] s2 [10] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h01, 8'h40, 8'h08, 8'h04};

  dsp_top #(.MOTOR_CYC(MT), .MOTOR525_CYC(400), .DIRCHG_CYC(DC), .SETTLE_CYC(ST)) dut_u (
    .core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .cmd_start, .cmd_write_type(cmd_wr), .ev_past_eot(ev[0]),
    .ev_crc_id(ev[1]), .ev_crc_data(ev[2]), .ev_overrun(ev[3]), .ev_no_data(ev[4]),
    .ev_id_mark_miss(ev[5]), .ev_dat_mark_miss(ev[6]), .ev_mark_mismatch(ev[7]),
    .trk_check, .medium_track(m_trk), .expected_track(e_trk), .ev_scan_equal(ev[8]),
    .ev_scan_miss(ev[9]), .flux_req, .op_ready, .idx_pulse, .rd_pulse, .sel_n,
    .motor_n, .dir_n, .step_n, .wdata_n, .wen_n, .head_n, .density_n, .index_n,
    .track0_n, .wprot_n, .rdata_n, .chg_n, .unit_kind_code(ukind), .medium_kind_code(mkind));
  dsp_drive_model drv_u (.core_clk, .sel_n, .motor_n, .dir_n, .step_n, .protect, .index_n,
    .track0_n, .wprot_n, .rdata_n, .chg_n, .ukind, .mkind);

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  function automatic logic sig(input int k);
    case (k)
      0: return step_n;
      1: return op_ready;
      2: return wen_n;
      default: return wdata_n;
    endcase
  endfunction : sig

  // every wait is bounded; running out ends the run as a failure
  task automatic wait_lvl(input int k, input logic lv, output int c);
    c = 0;
    while (sig(k) !== lv && c < 5000) begin
      @(posedge core_clk);
      c++;
    end
    if (c >= 5000) begin
      fail_count++;
      final_report();
    end
  endtask : wait_lvl

  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int c;
    c = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge core_clk);
      c++;
    end while (wb_ack_o !== 1'b1 && c < 50);
    if (c >= 50) begin
      fail_count++;
      final_report();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] ex);
    exp_q.push_back(ex);
    nm_q.push_back(nm);
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic pulse_cmd();
    cmd_start <= 1'b1;
    @(posedge core_clk);
    cmd_start <= 1'b0;
  endtask : pulse_cmd

  task automatic do_step(input logic inw, input int min_setup);
    int c;
    bus(1'b1, dsp_pkg::ADR_STEP, {7'h00, inw});
    wait_lvl(0, 1'b0, c);
    check("step setup", c + 2 >= min_setup, 1'b1);
    check("dir", dir_n, !inw);
    wait_lvl(0, 1'b1, c);
    check("step width", c, dsp_pkg::STEP_CYC);
    wait_lvl(1, 1'b1, c);
    check("settle", c >= ST, 1'b1);
  endtask : do_step

  // drive pulses seen by the block while the unit is selected
  always @(posedge core_clk) begin
    if (idx_pulse === 1'b1) n_idx++;
    if (rd_pulse === 1'b1) n_rd++;
  end

  // read results are scored when ack appears
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      check(nm_q.pop_front(), wb_dat_o, {24'h0, exp_q.pop_front()});
    end
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(1'b1, dsp_pkg::ADR_ST1, 8'hFF);
    rd("st1 ro", dsp_pkg::ADR_ST1, 8'h00);
    rd("unmapped", 8'h40, 8'h00);
    for (int i = 0; i < 10; i++) begin
      pulse_cmd();
      ev <= 10'h001 << i;
      @(posedge core_clk);
      ev <= 10'h000;
      @(posedge core_clk);
      rd("st1 ev", dsp_pkg::ADR_ST1, s1[i]);
      rd("st2 ev", dsp_pkg::ADR_ST2, s2[i]);
    end
    for (int i = 0; i < 5; i++) begin
      m = (i == 0) ? 8'hFF : 8'($random(seed));
      e = 8'($random(seed));
      pulse_cmd();
      m_trk <= m;
      e_trk <= e;
      trk_check <= 1'b1;
      @(posedge core_clk);
      trk_check <= 1'b0;
      @(posedge core_clk);
      rd("st1 trk", dsp_pkg::ADR_ST1, (m != e) ? 8'h04 : 8'h00);
      rd("st2 trk", dsp_pkg::ADR_ST2, {3'h0, m != e, 2'h0, m == 8'hFF && e != 8'hFF, 1'b0});
    end
    protect <= 1'b1;
    bus(1'b1, dsp_pkg::ADR_CTRL, 8'h35);
    repeat (8) @(posedge core_clk);
    check("density", density_n, 1'b0);
    check("head", head_n, 1'b0);
    check("select", sel_n, 1'b0);
    check("motor off", motor_n, 1'b1);
    rd("snapshot", dsp_pkg::ADR_ST3, 8'h7E);
    pulse_cmd();
    cmd_wr <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmd_wr <= 1'b0;
    @(posedge core_clk);
    rd("st1 wp", dsp_pkg::ADR_ST1, 8'h02);
    protect <= 1'b0;
    bus(1'b1, dsp_pkg::ADR_CTRL, 8'h1D);
    check("density", density_n, 1'b1);
    wait_lvl(1, 1'b1, n);
    check("motor wait", n + 2 >= MT, 1'b1);
    do_step(1'b1, 250);
    rd("snapshot", dsp_pkg::ADR_ST3, 8'h2E);
    do_step(1'b0, DC);
    rd("snapshot", dsp_pkg::ADR_ST3, 8'h3E);
    flux_req <= 1'b1;
    @(posedge core_clk);
    flux_req <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("gated flux", wdata_n, 1'b1);
    bus(1'b1, dsp_pkg::ADR_CTRL, 8'h9D);
    wait_lvl(2, 1'b0, n);
    flux_req <= 1'b1;
    @(posedge core_clk);
    flux_req <= 1'b0;
    wait_lvl(3, 1'b0, n);
    wait_lvl(3, 1'b1, n);
    check("flux width", n >= dsp_pkg::WPULSE_CYC, 1'b1);
    check("index seen", n_idx > 0, 1'b1);
    check("read seen", n_rd > 0, 1'b1);
    final_report();
  end
endmodule : tb_top
